// file: i2c_link_pkg.sv
// Purpose: Shared constants for the register access link, both ends
// Assumes: 100 MHz system clock, open-drain two-wire link with pull-ups
// Notes:   Offsets, field positions, reset values and cycle counts live here

package i2c_link_pkg;

  // ---------------------------------------------------------------
  // Device address map and layout
  // ---------------------------------------------------------------
  localparam logic [6:0]  CHIP_ADDR        = 7'h38;
  localparam logic [3:0]  CTRL_CODE_RESET  = 4'h7;
  localparam logic [10:0] VIRT_INPUT_ADDR  = 11'h0f4;
  localparam logic [10:0] FILTER_POL_ADDR  = 11'h0b6;
  localparam logic [10:0] CTRL_CODE_ADDR   = 11'h0e9;
  localparam logic [7:0]  VIRT_INPUT_RESET = 8'h00;
  localparam logic [7:0]  FILTER_POL_RESET = 8'h00;
  localparam logic [7:0]  FILTER_POL_MASK  = 8'h44;
  localparam int          FILT1_POL_BIT    = 2;
  localparam int          FILT0_POL_BIT    = 6;

  // ---------------------------------------------------------------
  // Controller register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_OFFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFFS = 8'h04;
  localparam logic [7:0]  CODE_OFFS   = 8'h08;
  localparam int          CMD_ADDR_LSB  = 0;
  localparam int          CMD_OP_LSB    = 12;
  localparam int          CMD_WDATA_LSB = 16;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_NACK_BIT = 1;
  localparam int          STAT_RDATA_LSB = 8;
  localparam logic [1:0]  OP_WRITE   = 2'h0;
  localparam logic [1:0]  OP_RANDOM  = 2'h1;
  localparam logic [1:0]  OP_CURRENT = 2'h2;

  // ---------------------------------------------------------------
  // Link timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS     = 2500;
  localparam int QUARTER_CYC =
    (SCL_PERIOD_NS / 4 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);

endpackage

// file: i2c_link_if.sv
// Purpose: Two-wire link between controller and register slave
// Assumes: Both wires pulled up; enables only ever pull low
// Notes:   Resolves the wired-AND levels from the drivers' enables
`timescale 1ns/1ps
`default_nettype none

interface i2c_link_if;
  logic scl;          // Resolved clock wire
  logic sda;          // Resolved data wire
  logic host_scl_o;   // Controller clock drive value
  logic host_scl_oe;  // Controller clock drive enable
  logic host_sda_o;   // Controller data drive value
  logic host_sda_oe;  // Controller data drive enable
  logic dev_sda_o;    // Slave data drive value
  logic dev_sda_oe;   // Slave data drive enable

  // Open-drain resolution with pull-up
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (input scl, sda, output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
  modport device (input scl, sda, output dev_sda_o, dev_sda_oe);
endinterface

`default_nettype wire

// file: i2c_link_host.sv
// Purpose: Link controller issuing byte write, random and current reads
// Assumes: No clock stretching by the slave
// Notes:   Link clock made by a divider; four quarters per bit
`timescale 1ns/1ps
`default_nettype none

module i2c_link_host (
  input  wire logic        ref_clk_in,  // System clock
  input  wire logic        srst_in,     // Sync reset, active high
  i2c_link_if.host         link,        // Link pins
  input  wire logic [7:0]  addr_in,     // Register offset
  input  wire logic [31:0] wr_data_in,  // Write data
  input  wire logic        wr_en_in,    // Write strobe
  input  wire logic        rd_en_in,    // Read strobe
  output logic      [31:0] rd_data_out  // Read data, next cycle
);

  typedef enum {H_IDLE, H_START, H_CTRL_W, H_WORD, H_DATA, H_RESTART,
                H_CTRL_R, H_READ, H_STOP} step_e;

  step_e       step_q;
  logic [7:0]  div_q;
  logic [1:0]  qtr_q;
  logic [3:0]  bit_q;
  logic [7:0]  rx_q;
  logic [7:0]  rdata_q;
  logic        nack_q;
  logic        go_q;
  logic [10:0] addr_q;
  logic [1:0]  op_q;
  logic [7:0]  wdata_q;
  logic [3:0]  code_q;
  logic        scl_oe_q;
  logic        sda_oe_q;
  logic        sda_s1_q;
  logic        sda_s2_q;
  logic        tick;
  logic        busy;
  logic [7:0]  cur_byte;

  // Byte sent in each step
  function automatic logic [7:0] step_byte(input step_e s, input logic [3:0] c,
                                           input logic [10:0] a, input logic [7:0] w);
    case (s)
      H_CTRL_W: step_byte = {c, a[10:8], 1'b0};
      H_WORD:   step_byte = a[7:0];
      H_DATA:   step_byte = w;
      H_CTRL_R: step_byte = {c, a[10:8], 1'b1};
      default:  step_byte = 8'hff;
    endcase
  endfunction

  // Step that follows a finished symbol or byte
  function automatic step_e next_step(input step_e s, input logic [1:0] op);
    case (s)
      H_START:   next_step = (op == i2c_link_pkg::OP_CURRENT) ? H_CTRL_R : H_CTRL_W;
      H_CTRL_W:  next_step = H_WORD;
      H_WORD:    next_step = (op == i2c_link_pkg::OP_WRITE) ? H_DATA : H_RESTART;
      H_RESTART: next_step = H_CTRL_R;
      H_CTRL_R:  next_step = H_READ;
      H_READ:    next_step = H_STOP;
      H_DATA:    next_step = H_STOP;
      default:   next_step = H_IDLE;
    endcase
  endfunction

  assign tick     = (div_q == i2c_link_pkg::QUARTER_LAST);
  assign busy     = (step_q != H_IDLE);
  assign cur_byte = step_byte(step_q, code_q, addr_q, wdata_q);

  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_oe = sda_oe_q;

  // ---------------------------------------------------------------
  // Data line synchroniser and quarter-bit divider
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    sda_s1_q <= link.sda;
    sda_s2_q <= sda_s1_q;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !busy || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer and pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      step_q   <= H_IDLE;
      qtr_q    <= 2'h0;
      bit_q    <= 4'h0;
      rx_q     <= 8'h00;
      rdata_q  <= 8'h00;
      nack_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (step_q == H_IDLE) begin
      if (go_q) begin
        step_q <= H_START;
        qtr_q  <= 2'h0;
        bit_q  <= 4'h0;
        nack_q <= 1'b0;
      end
    end else if (tick) begin
      qtr_q <= qtr_q + 2'h1;
      case (step_q)
        H_START, H_RESTART: begin
          // Data falls while the clock is high
          case (qtr_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1;
            default: begin
              scl_oe_q <= 1'b1;
              step_q   <= next_step(step_q, op_q);
            end
          endcase
        end
        H_STOP: begin
          // Data rises while the clock is high
          case (qtr_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0;
            default: step_q <= H_IDLE;
          endcase
        end
        default: begin
          case (qtr_q)
            2'h0: sda_oe_q <= (bit_q < 4'h8) && !cur_byte[3'(4'h7 - bit_q)];
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
              if (bit_q < 4'h8) begin
                rx_q <= {rx_q[6:0], sda_s2_q};
              end else if (step_q != H_READ && sda_s2_q) begin
                nack_q <= 1'b1;
              end
            end
            default: begin
              scl_oe_q <= 1'b1;
              if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                if (step_q == H_READ) begin
                  rdata_q <= rx_q;
                end
                // A refused byte ends the transfer at once
                step_q <= nack_q ? H_STOP : next_step(step_q, op_q);
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          endcase
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      go_q    <= 1'b0;
      addr_q  <= 11'h000;
      op_q    <= 2'h0;
      wdata_q <= 8'h00;
      code_q  <= i2c_link_pkg::CTRL_CODE_RESET;
    end else begin
      go_q <= 1'b0;
      if (wr_en_in && addr_in == i2c_link_pkg::CMD_OFFS && !busy && !go_q) begin
        addr_q  <= wr_data_in[i2c_link_pkg::CMD_ADDR_LSB +: 11];
        op_q    <= wr_data_in[i2c_link_pkg::CMD_OP_LSB +: 2];
        wdata_q <= wr_data_in[i2c_link_pkg::CMD_WDATA_LSB +: 8];
        go_q    <= 1'b1;
      end
      if (wr_en_in && addr_in == i2c_link_pkg::CODE_OFFS) begin
        code_q <= wr_data_in[3:0];
      end
    end
  end

  // Read port, unmapped offsets read zero
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rd_data_out <= 32'h0000_0000;
    end else if (rd_en_in) begin
      rd_data_out <= 32'h0000_0000;
      case (addr_in)
        i2c_link_pkg::CMD_OFFS: begin
          rd_data_out[i2c_link_pkg::CMD_ADDR_LSB +: 11] <= addr_q;
          rd_data_out[i2c_link_pkg::CMD_OP_LSB +: 2]    <= op_q;
          rd_data_out[i2c_link_pkg::CMD_WDATA_LSB +: 8] <= wdata_q;
        end
        i2c_link_pkg::STATUS_OFFS: begin
          rd_data_out[i2c_link_pkg::STAT_BUSY_BIT]       <= busy || go_q;
          rd_data_out[i2c_link_pkg::STAT_NACK_BIT]       <= nack_q;
          rd_data_out[i2c_link_pkg::STAT_RDATA_LSB +: 8] <= rdata_q;
        end
        i2c_link_pkg::CODE_OFFS: rd_data_out[3:0] <= code_q;
        default: rd_data_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule // i2c_link_host

`default_nettype wire

// file: i2c_register_access_slave.sv
// Purpose: Two-wire register slave holding control and polarity bytes
// Assumes: Link clock is slow against the system clock (oversampled)
// Notes:   Eleven-bit byte space; unmapped bytes read zero, writes drop
`timescale 1ns/1ps
`default_nettype none

module i2c_register_access_slave (
  input  wire logic ref_clk_in,                          // System clock
  input  wire logic srst_in,                             // Sync reset, active high
  i2c_link_if.device link,                               // Link pins
  output logic      sleep_enable_out,                    // Sleep enable
  output logic      power_button_select_out,             // Power button select
  output logic      timer_start_out,                     // Timer start
  output logic      power_button_irq_enable_clear_n_out, // Button irq clear, low
  output logic      sleep_button_irq_enable_clear_n_out, // Sleep irq clear, low
  output logic      power_good_irq_enable_clear_n_out,   // Power good clear, low
  output logic      spare_input_irq_enable_clear_n_out,  // Spare irq clear, low
  output logic      timeout_irq_enable_clear_n_out,      // Timeout clear, low
  output logic      filter1_polarity_out,                // Filter one polarity
  output logic      filter0_polarity_out                 // Filter zero polarity
);

  typedef enum {S_IDLE, S_CTRL, S_WORD, S_WDATA, S_ACK, S_TX, S_TX_ACK} slv_state_e;

  slv_state_e  state_q;
  slv_state_e  next_q;
  logic [3:0]  cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [2:0]  block_q;
  logic [10:0] ptr_q;
  logic        drive_q;
  logic [7:0]  vin_q;
  logic [7:0]  fpol_q;
  logic [3:0]  code_q;
  logic        scl_s1_q;
  logic        scl_s2_q;
  logic        scl_p_q;
  logic        sda_s1_q;
  logic        sda_s2_q;
  logic        sda_p_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        wr_commit;
  logic [7:0]  rd_now;

  // Byte seen by a read at a given address
  function automatic logic [7:0] read_byte(input logic [10:0] a, input logic [7:0] vin,
                                           input logic [7:0] fpol, input logic [3:0] code);
    case (a)
      i2c_link_pkg::VIRT_INPUT_ADDR: read_byte = vin;
      i2c_link_pkg::FILTER_POL_ADDR: read_byte = fpol & i2c_link_pkg::FILTER_POL_MASK;
      i2c_link_pkg::CTRL_CODE_ADDR:  read_byte = {4'h0, code};
      default:                       read_byte = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  // Two stages before use, a third stage for edges
  always_ff @(posedge ref_clk_in) begin
    scl_s1_q <= link.scl;
    scl_s2_q <= scl_s1_q;
    sda_s1_q <= link.sda;
    sda_s2_q <= sda_s1_q;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s2_q;
      sda_p_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q && !scl_p_q;
  assign scl_fall = !scl_s2_q && scl_p_q;
  // Data moving while the clock stays high marks start or stop
  assign start_ev = scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
  assign stop_ev  = scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;

  assign rd_now    = read_byte(ptr_q, vin_q, fpol_q, code_q);
  assign wr_commit = scl_fall && (state_q == S_WDATA) && (cnt_q == 4'h8);

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q <= S_IDLE;
      next_q  <= S_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      block_q <= 3'h0;
      ptr_q   <= 11'h000;
      drive_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= S_IDLE;
      drive_q <= 1'b0;
    end else if (start_ev) begin
      // Pointer survives a repeated start; any write in flight is dropped
      state_q <= S_CTRL;
      cnt_q   <= 4'h0;
      drive_q <= 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        S_CTRL, S_WORD, S_WDATA: begin
          if (cnt_q < 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            cnt_q   <= cnt_q + 4'h1;
          end
        end
        S_TX_ACK: begin
          // Pointer steps after each byte sent
          ptr_q <= ptr_q + 11'h001;
          if (sda_s2_q) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= S_ACK;
            next_q  <= S_TX;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        S_CTRL: begin
          if (cnt_q == 4'h8) begin
            if (shift_q[7:4] == code_q) begin
              block_q <= shift_q[3:1];
              next_q  <= shift_q[0] ? S_TX : S_WORD;
              drive_q <= 1'b1;
              state_q <= S_ACK;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_WORD: begin
          if (cnt_q == 4'h8) begin
            ptr_q   <= {block_q, shift_q};
            next_q  <= S_WDATA;
            drive_q <= 1'b1;
            state_q <= S_ACK;
          end
        end
        S_WDATA: begin
          if (cnt_q == 4'h8) begin
            next_q  <= S_IDLE;
            drive_q <= 1'b1;
            state_q <= S_ACK;
          end
        end
        S_ACK: begin
          // Acknowledge clock ends; release or put out first bit
          cnt_q   <= 4'h0;
          state_q <= next_q;
          if (next_q == S_TX) begin
            tx_q    <= rd_now;
            drive_q <= !rd_now[7];
          end else begin
            drive_q <= 1'b0;
          end
        end
        S_TX: begin
          if (cnt_q == 4'h7) begin
            drive_q <= 1'b0;
            state_q <= S_TX_ACK;
          end else begin
            tx_q    <= {tx_q[6:0], 1'b0};
            drive_q <= !tx_q[6];
            cnt_q   <= cnt_q + 4'h1;
          end
        end
        default: drive_q <= 1'b0;
      endcase
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = drive_q;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  // Written on the edge the data acknowledge starts
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      vin_q  <= i2c_link_pkg::VIRT_INPUT_RESET;
      fpol_q <= i2c_link_pkg::FILTER_POL_RESET;
      code_q <= i2c_link_pkg::CTRL_CODE_RESET;
    end else if (wr_commit) begin
      case (ptr_q)
        i2c_link_pkg::VIRT_INPUT_ADDR: vin_q <= shift_q;
        i2c_link_pkg::FILTER_POL_ADDR:
          fpol_q <= shift_q & i2c_link_pkg::FILTER_POL_MASK;
        i2c_link_pkg::CTRL_CODE_ADDR:  code_q <= shift_q[3:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  // Virtual input byte fans out bit by bit
  assign sleep_enable_out                    = vin_q[0];
  assign power_button_select_out             = vin_q[1];
  assign timer_start_out                     = vin_q[2];
  assign power_button_irq_enable_clear_n_out = vin_q[3];
  assign sleep_button_irq_enable_clear_n_out = vin_q[4];
  assign power_good_irq_enable_clear_n_out   = vin_q[5];
  assign spare_input_irq_enable_clear_n_out  = vin_q[6];
  assign timeout_irq_enable_clear_n_out      = vin_q[7];

  // Filter polarity selects
  assign filter1_polarity_out = fpol_q[i2c_link_pkg::FILT1_POL_BIT];
  assign filter0_polarity_out = fpol_q[i2c_link_pkg::FILT0_POL_BIT];

endmodule // i2c_register_access_slave

`default_nettype wire

// file: i2c_register_access_slave_checker.sv
// Purpose: Protocol checks on the two-wire link joining both ends
// Assumes: Open-drain wires with pull-ups, one 100 MHz domain
// Notes:   A bit is four quarters of 63 cycles; low phase is two
`timescale 1ns/1ps
`default_nettype none

module i2c_register_access_slave_checker (
  input wire logic ref_clk_in,  // System clock
  input wire logic srst_in,     // Sync reset, active high
  input wire logic scl,         // Resolved clock wire
  input wire logic sda,         // Resolved data wire
  input wire logic host_scl_o,  // Controller clock value
  input wire logic host_scl_oe, // Controller clock enable
  input wire logic host_sda_o,  // Controller data value
  input wire logic host_sda_oe, // Controller data enable
  input wire logic dev_sda_o,   // Slave data value
  input wire logic dev_sda_oe   // Slave data enable
);
  logic [11:0] lo_q; // Cycles with clock low
  logic [11:0] hi_q; // Cycles with clock high, saturating
  logic [11:0] oe_q; // Cycles the slave pulls data low

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // ---------------------------------------------------------------
  // Phase length counters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      lo_q <= 12'h000;
      hi_q <= 12'h000;
      oe_q <= 12'h000;
    end else begin
      lo_q <= scl ? 12'h000 : lo_q + 12'h001;
      hi_q <= !scl ? 12'h000 : (&hi_q ? hi_q : hi_q + 12'h001);
      oe_q <= dev_sda_oe ? oe_q + 12'h001 : 12'h000;
    end
  end

  // ---------------------------------------------------------------
  // Link properties
  // ---------------------------------------------------------------
  property p_open_drain;
    (host_scl_oe || host_sda_oe || dev_sda_oe) |-> !host_scl_o && !host_sda_o && !dev_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("driver drives high");
  property p_quiet_after_reset;
    $fell(srst_in) |-> !dev_sda_oe && !host_scl_oe && !host_sda_oe;
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("pulled low");
  property p_dev_moves_scl_low;
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 2);
  endproperty
  a_dev_moves_scl_low: assert property (p_dev_moves_scl_low) else $error("sda moved");
  property p_start_dev_free;
    $fell(sda) && scl && $past(scl) |-> !dev_sda_oe;
  endproperty
  a_start_dev_free: assert property (p_start_dev_free) else $error("slave pulls at start");
  property p_stop_dev_free;
    $rose(sda) && scl |-> !dev_sda_oe ##1 !dev_sda_oe;
  endproperty
  a_stop_dev_free: assert property (p_stop_dev_free) else $error("slave pulls at stop");
  property p_low_two_quarters;
    $rose(scl) |-> lo_q inside {[12'd120:12'd130]};
  endproperty
  a_low_two_quarters: assert property (p_low_two_quarters) else $error("scl low width");
  property p_dev_hold_bound;
    oe_q <= 12'd2300;
  endproperty
  a_dev_hold_bound: assert property (p_dev_hold_bound) else $error("slave holds sda");
  property p_idle_released;
    hi_q > 12'd200 |-> !dev_sda_oe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("slave pulls idle");

  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_start: cover property ($fell(sda) && scl);
  c_zero_byte: cover property (oe_q > 12'd2000);
endmodule // i2c_register_access_slave_checker

`default_nettype wire

// file: i2c_register_access_slave_test.sv
// Purpose: Drives the controller against the slave over the link
// Assumes: Controller register map and package constants
// Notes:   Expectations are kept in the bench, not read from design
`timescale 1ns/1ps
`default_nettype none

module i2c_register_access_slave_test;
  logic        ref_clk_in  = 1'b0;
  logic        srst_in     = 1'b1;
  logic [7:0]  addr_in     = 8'h00;
  logic [31:0] wr_data_in  = 32'h0;
  logic        wr_en_in    = 1'b0;
  logic        rd_en_in    = 1'b0;
  logic [31:0] rd_data_out;
  logic [31:0] st;
  logic [15:0] seed        = 16'hb0a0;
  wire  [7:0]  vin;
  logic [7:0]  fp;
  logic [7:0]  vi;
  logic [7:0]  d;
  logic        f0;
  logic        f1;
  int          miscompares = 0;
  int          tests_run   = 0;

  i2c_link_if link_bus ();
  assign fp = {1'b0, f0, 3'b000, f1, 2'b00};
  always #5 ref_clk_in = ~ref_clk_in;

  // ---------------------------------------------------------------
  // Both ends and the checker
  // ---------------------------------------------------------------
  i2c_link_host i_i2c_link_host (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .link(link_bus.host), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out));
  i2c_register_access_slave i_i2c_register_access_slave (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .link(link_bus.device), .sleep_enable_out(vin[0]),
    .power_button_select_out(vin[1]), .timer_start_out(vin[2]),
    .power_button_irq_enable_clear_n_out(vin[3]), .sleep_button_irq_enable_clear_n_out(vin[4]),
    .power_good_irq_enable_clear_n_out(vin[5]), .spare_input_irq_enable_clear_n_out(vin[6]),
    .timeout_irq_enable_clear_n_out(vin[7]), .filter1_polarity_out(f1),
    .filter0_polarity_out(f0));
  i2c_register_access_slave_checker i_i2c_register_access_slave_checker (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .scl(link_bus.scl), .sda(link_bus.sda), .host_scl_o(link_bus.host_scl_o),
    .host_scl_oe(link_bus.host_scl_oe), .host_sda_o(link_bus.host_sda_o),
    .host_sda_oe(link_bus.host_sda_oe), .dev_sda_o(link_bus.dev_sda_o),
    .dev_sda_oe(link_bus.dev_sda_oe));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction

  // Filter byte with the two selects at their rule positions
  function automatic logic [7:0] exp_fpol(input logic [7:0] v);
    return {1'b0, v[6], 3'b000, v[2], 2'b00};
  endfunction

  // One strobe cycle; read data is taken at the following edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
    addr_in <= a;
    wr_data_in <= wd;
    wr_en_in <= we;
    rd_en_in <= !we;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  // Issues one link command and polls until the controller is idle
  task automatic xfer(input logic [1:0] op, input logic [10:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    bus(1'b1, i2c_link_pkg::CMD_OFFS, {8'h00, wd, 2'b00, op, 1'b0, a});
    do begin
      bus(1'b0, i2c_link_pkg::STATUS_OFFS, 32'h0);
      n++;
    end while (rd_data_out[0] !== 1'b0 && n < 6000);
    if (n >= 6000) begin
      miscompares++;
      $display("[ERR] busy expected 0 seen 1");
    end
    st = rd_data_out;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    chk("virtual inputs", 8'h00, vin);
    chk("filter polarity", 8'h00, fp);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      vi = (i == 0) ? 8'hff : seed[7:0];
      xfer(i2c_link_pkg::OP_WRITE, 11'h0f4, vi);
      chk("write nack", 8'h00, {7'h00, st[1]});
      chk("virtual inputs", vi, vin);
    end
    xfer(i2c_link_pkg::OP_WRITE, 11'h1f4, ~vi);
    chk("other block", vi, vin);
    d = seed[15:8];
    xfer(i2c_link_pkg::OP_WRITE, 11'h0b6, d);
    chk("filter polarity", exp_fpol(d), fp);
    xfer(i2c_link_pkg::OP_RANDOM, 11'h0f4, 8'h00);
    chk("random read", vi, st[15:8]);
    xfer(i2c_link_pkg::OP_RANDOM, 11'h0b5, 8'h00);
    chk("unmapped read", 8'h00, st[15:8]);
    xfer(i2c_link_pkg::OP_CURRENT, 11'h000, 8'h00);
    chk("current read", exp_fpol(d), st[15:8]);
    bus(1'b1, i2c_link_pkg::CODE_OFFS, 32'h5);
    xfer(i2c_link_pkg::OP_WRITE, 11'h0f4, ~vi);
    chk("wrong code nack", 8'h01, {7'h00, st[1]});
    chk("virtual inputs", vi, vin);
    bus(1'b1, i2c_link_pkg::CODE_OFFS, 32'h7);
    xfer(i2c_link_pkg::OP_WRITE, 11'h0e9, 8'h05);
    bus(1'b1, i2c_link_pkg::CODE_OFFS, 32'h5);
    bus(1'b0, i2c_link_pkg::CODE_OFFS, 32'h0);
    chk("code readback", 8'h05, rd_data_out[7:0]);
    xfer(i2c_link_pkg::OP_WRITE, 11'h0f4, ~vi);
    chk("new code write", ~vi, vin);
    conclude();
  end

  // Cuts a hang short
  initial begin
    #900_000;
    miscompares++;
    $display("[ERR] run expected done seen timeout");
    conclude();
  end
endmodule // i2c_register_access_slave_test

`default_nettype wire
